// >>> rtl/can_diag_pkg.sv
package can_diag_pkg;
  // ==========================================================================
  // register map (byte addresses, one 32-bit word each)
  localparam logic [7:0]  OFS_GLOBAL_CONFIG  = 8'h00;
  localparam logic [7:0]  OFS_ERROR_COUNTERS = 8'h04;
  localparam logic [7:0]  OFS_ERROR_DIAG     = 8'h08;
  localparam logic [7:0]  OFS_STAMP_COUNTER  = 8'h0C;
  localparam logic [7:0]  OFS_BIT_TIMING     = 8'h10;
  localparam logic [7:0]  OFS_PROC_STATUS    = 8'h14;

  // ==========================================================================
  // register index returned by the address decoder
  typedef enum logic [2:0] {
    IDX_CONFIG  = 3'h0,
    IDX_ERRCNT  = 3'h1,
    IDX_DIAG    = 3'h2,
    IDX_STAMP   = 3'h3,
    IDX_TIMING  = 3'h4,
    IDX_STATUS  = 3'h5,
    IDX_NONE    = 3'h7
  } reg_index_e;

  // ==========================================================================
  // global configuration fields
  localparam int CFG_ENABLE_BIT  = 0;
  localparam int CFG_STAMP_BIT   = 1;
  localparam int CFG_TXPOL_BIT   = 2;
  localparam int CFG_RXPOL_BIT   = 3;
  localparam int CFG_W           = 4;
  localparam logic [3:0] CFG_RESET = 4'h0;

  // bit timing fields and biases
  localparam int TIM_PSC_LSB  = 0;
  localparam int TIM_PSC_W    = 6;
  localparam int TIM_SEG1_LSB = 6;
  localparam int TIM_SEG1_W   = 4;
  localparam int TIM_SEG2_LSB = 10;
  localparam int TIM_SEG2_W   = 3;
  localparam int TIM_W        = 13;
  localparam logic [12:0] TIM_RESET = 13'h0000;
  localparam logic [15:0] PSC_BIAS  = 16'h0002;
  localparam logic [15:0] SEG_BIAS  = 16'h0001;
  localparam logic [15:0] SYNC_TQ   = 16'h0001;
  localparam int          BUDGET_BITS_SHIFT = 2;  // four bit times

  // error diagnostic fields
  localparam int DG_CODE_LSB  = 0;
  localparam int DG_POS_LSB   = 4;
  localparam int DG_TXE_BIT   = 10;
  localparam int DG_STUFF_BIT = 11;
  localparam int DG_CRC_BIT   = 12;
  localparam int DG_MON_BIT   = 13;
  localparam int DG_DRIVE_BIT = 14;
  localparam int DG_RES_BIT   = 15;
  localparam logic [15:0] REG16_RESET = 16'h0000;

  // processing status fields
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_OVERRUN_BIT = 1;
  localparam int ST_SLOWCLK_BIT = 2;

  // frame field codes
  typedef enum logic [3:0] {
    FLD_ERROR = 4'h0, FLD_ERROR_DEL = 4'h1, FLD_ERROR_ECHO = 4'h2, FLD_BUS_IDLE = 4'h3,
    FLD_ACK   = 4'h4, FLD_EOF       = 4'h5, FLD_INTERMISSION = 4'h6, FLD_SUSPEND = 4'h7,
    FLD_SOF   = 4'h8, FLD_ARB       = 4'h9, FLD_IDE   = 4'hA, FLD_EXT_ARB = 4'hB,
    FLD_R1R0  = 4'hC, FLD_LENGTH    = 4'hD, FLD_DATA  = 4'hE, FLD_CRC     = 4'hF
  } field_code_e;

  // ==========================================================================
  // internal processing budgets in clock cycles
  localparam logic [4:0]  COPY_CYCLES     = 5'd17;
  localparam logic [4:0]  PROMOTE_CYCLES  = 5'd3;
  localparam logic [4:0]  SCHEDULE_CYCLES = 5'd2;
  localparam logic [15:0] WORST_CASE_CYCLES = 16'd61;  // 17 + 14*3 + 2
  localparam logic        RECESSIVE = 1'b1;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00, SEQ_COPY = 2'b01, SEQ_PROMOTE = 2'b11, SEQ_SCHEDULE = 2'b10
  } seq_state_e;
endpackage

// >>> rtl/can_error_diag_timestamp.sv
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - error counter register: receive count high byte, transmit low byte, read-only
// - diagnostic register read-only, zero after reset, top bit reserved
// - every detected error overwrites diagnostic with latest field and bit position
// - field codes 0 to 7: flag, delimiter, echo, idle, ack, eof, pause, suspend
// - field codes 8 to 15: sof, arbitration, ide, ext arb, r1r0, length, data, crc
// - bit position loads field length minus one, decrements each bus bit
// - bit 10 shows whether the node was transmitting at the error
// - bit 11 flags a stuffing violation
// - bit 12 flags a bad received crc, meaningful with ack code
// - bit 13 holds receive level sampled at the error
// - bit 14 holds transmit pin value at the error
// - stamp counter: free running 16 bits, one per bus bit, zero after reset
// - with stamp enable, buffer 0 transfer clears the stamp counter
// - finished frame copies stamp counter into the buffer stamp field
// - disabling blocks the receive pin; registers keep contents
// - transmit and receive pins with configurable polarity each
// - copy takes 17 cycles, promote 3 per buffer, schedule 2
// - remote frame answer processing must fit in four bit times
// - minimum timing gives six clock cycles per bit
module can_error_diag_timestamp (
  // apb slave
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // bus pins
  input  wire logic                     receive_pin,
  output logic                          transmit_pin,
  // protocol engine side
  input  wire logic                     tx_bit,
  output logic                          rx_bit,
  output logic                          module_enable,
  output logic      [12:0]              bit_timing_config,
  input  wire logic                     bit_tick,
  input  wire logic                     field_start,
  input  wire can_diag_pkg::field_code_e field_code,
  input  wire logic [6:0]               field_length,
  input  wire logic                     error_detect,
  input  wire logic                     error_stuff,
  input  wire logic                     error_crc,
  input  wire logic                     transmitting,
  input  wire logic [7:0]               receive_error_count,
  input  wire logic [7:0]               transmit_error_count,
  // buffer side
  input  wire logic                     buf0_transfer_done,
  input  wire logic                     frame_done,
  input  wire logic [3:0]               frame_buffer,
  output logic                          stamp_write,
  output logic      [15:0]              stamp_value,
  output logic      [3:0]               stamp_buffer,
  // remote frame processing
  input  wire logic                     remote_frame_valid,
  input  wire logic [3:0]               promote_count,
  output logic                          proc_busy,
  output logic                          proc_done
);
  import can_diag_pkg::*;

  // ==========================================================================
  // address decode
  function automatic reg_index_e decode(input logic [7:0] a);
    case (a)
      OFS_GLOBAL_CONFIG:  decode = IDX_CONFIG;
      OFS_ERROR_COUNTERS: decode = IDX_ERRCNT;
      OFS_ERROR_DIAG:     decode = IDX_DIAG;
      OFS_STAMP_COUNTER:  decode = IDX_STAMP;
      OFS_BIT_TIMING:     decode = IDX_TIMING;
      OFS_PROC_STATUS:    decode = IDX_STATUS;
      default:            decode = IDX_NONE;
    endcase
  endfunction

  logic [CFG_W-1:0]  config_reg;
  logic [TIM_W-1:0]  timing_reg;
  logic [15:0]       error_counters_reg;
  logic [15:0]       error_diagnostic_reg;
  logic [15:0]       bit_time_stamp_counter_reg;
  logic [5:0]        bit_position_reg;
  field_code_e       field_code_reg;
  logic              rx_level_reg;
  logic              overrun_reg;
  logic              slow_clock_reg;
  seq_state_e        seq_state_reg;
  logic [4:0]        seq_count_reg;
  logic [3:0]        promote_left_reg;
  logic [15:0]       window_reg;
  logic              wr_access;
  logic              setup_phase;
  reg_index_e        wr_index;
  logic [15:0]       bit_cycles;
  logic [15:0]       budget_cycles;
  logic              seq_start;
  logic              seq_finish;
  logic              time_stamp_enable;

  assign setup_phase       = psel && !penable;
  assign wr_access         = psel && penable && pready && pwrite;
  assign wr_index          = decode(paddr);
  assign time_stamp_enable = config_reg[CFG_STAMP_BIT];

  // ==========================================================================
  // apb answer: zero wait states, data loaded in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase && (decode(paddr) == IDX_NONE);
      if (setup_phase && !pwrite) begin
        case (decode(paddr))
          IDX_CONFIG: prdata <= {28'h000_0000, config_reg};
          IDX_ERRCNT: prdata <= {16'h0000, error_counters_reg};
          IDX_DIAG:   prdata <= {16'h0000, error_diagnostic_reg};
          IDX_STAMP:  prdata <= {16'h0000, bit_time_stamp_counter_reg};
          IDX_TIMING: prdata <= {19'h0_0000, timing_reg};
          IDX_STATUS: prdata <= {29'h0000_0000, slow_clock_reg, overrun_reg, proc_busy};
          default:    prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================================
  // writable configuration; contents held while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= CFG_RESET;
      timing_reg <= TIM_RESET;
    end else if (wr_access) begin
      if (wr_index == IDX_CONFIG) begin
        config_reg <= pwdata[CFG_W-1:0];
      end
      if (wr_index == IDX_TIMING) begin
        timing_reg <= pwdata[TIM_W-1:0];
      end
    end
  end

  // configuration out to the bit time logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_enable     <= 1'b0;
      bit_timing_config <= TIM_RESET;
    end else begin
      module_enable     <= config_reg[CFG_ENABLE_BIT];
      bit_timing_config <= timing_reg;
    end
  end

  // ==========================================================================
  // pin polarity and receive gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_pin <= RECESSIVE;
      rx_level_reg <= RECESSIVE;
      rx_bit       <= RECESSIVE;
    end else begin
      transmit_pin <= tx_bit ^ config_reg[CFG_TXPOL_BIT];
      rx_level_reg <= receive_pin ^ config_reg[CFG_RXPOL_BIT];
      rx_bit       <= config_reg[CFG_ENABLE_BIT] ? rx_level_reg : RECESSIVE;
    end
  end

  // ==========================================================================
  // error counters mirrored read-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_counters_reg <= REG16_RESET;
    end else begin
      error_counters_reg <= {receive_error_count, transmit_error_count};
    end
  end

  // field tracker: code and bit position within the current field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      field_code_reg   <= FLD_ERROR;
      bit_position_reg <= 6'h00;
    end else if (field_start) begin
      field_code_reg   <= field_code;
      bit_position_reg <= 6'(field_length - 7'h01);
    end else if (bit_tick) begin
      bit_position_reg <= bit_position_reg - 6'h01;
    end
  end

  // last error capture; top bit stays zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_diagnostic_reg <= REG16_RESET;
    end else if (error_detect) begin
      error_diagnostic_reg[DG_RES_BIT]   <= 1'b0;
      error_diagnostic_reg[DG_DRIVE_BIT] <= transmit_pin;
      error_diagnostic_reg[DG_MON_BIT]   <= rx_level_reg;
      error_diagnostic_reg[DG_CRC_BIT]   <= error_crc;
      error_diagnostic_reg[DG_STUFF_BIT] <= error_stuff;
      error_diagnostic_reg[DG_TXE_BIT]   <= transmitting;
      error_diagnostic_reg[DG_TXE_BIT-1:DG_POS_LSB] <= bit_position_reg;
      error_diagnostic_reg[DG_POS_LSB-1:DG_CODE_LSB] <= field_code_reg;
    end
  end

  // ==========================================================================
  // bit time stamp counter; buffer 0 clear wins over the bit tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_time_stamp_counter_reg <= REG16_RESET;
    end else if (time_stamp_enable && buf0_transfer_done) begin
      bit_time_stamp_counter_reg <= REG16_RESET;
    end else if (bit_tick) begin
      bit_time_stamp_counter_reg <= bit_time_stamp_counter_reg + 16'h0001;
    end
  end

  // stamp handed to the buffer of a finished frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stamp_write  <= 1'b0;
      stamp_value  <= REG16_RESET;
      stamp_buffer <= 4'h0;
    end else begin
      stamp_write <= frame_done;
      if (frame_done) begin
        stamp_value  <= bit_time_stamp_counter_reg;
        stamp_buffer <= frame_buffer;
      end
    end
  end

  // ==========================================================================
  // bit length in clocks and the four-bit budget
  assign bit_cycles = 16'(({10'h000, timing_reg[TIM_PSC_LSB +: TIM_PSC_W]} + PSC_BIAS)
                    * (SYNC_TQ + {12'h000, timing_reg[TIM_SEG1_LSB +: TIM_SEG1_W]} + SEG_BIAS
                    + {13'h0000, timing_reg[TIM_SEG2_LSB +: TIM_SEG2_W]} + SEG_BIAS));
  assign budget_cycles = bit_cycles << BUDGET_BITS_SHIFT;

  // low clock warning against the worst-case answer load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_clock_reg <= 1'b0;
    end else begin
      slow_clock_reg <= budget_cycles < WORST_CASE_CYCLES;
    end
  end

  // ==========================================================================
  // remote frame answer sequencer
  assign seq_start  = remote_frame_valid && (seq_state_reg == SEQ_IDLE);
  assign seq_finish = (seq_state_reg == SEQ_SCHEDULE) && (seq_count_reg == 5'd0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_state_reg    <= SEQ_IDLE;
      seq_count_reg    <= 5'd0;
      promote_left_reg <= 4'h0;
    end else begin
      case (seq_state_reg)
        SEQ_IDLE: begin
          if (seq_start) begin
            seq_state_reg    <= SEQ_COPY;
            seq_count_reg    <= COPY_CYCLES - 5'd1;
            promote_left_reg <= promote_count;
          end
        end
        SEQ_COPY, SEQ_PROMOTE: begin
          if (seq_count_reg != 5'd0) begin
            seq_count_reg <= seq_count_reg - 5'd1;
          end else if (promote_left_reg != 4'h0) begin
            seq_state_reg    <= SEQ_PROMOTE;
            seq_count_reg    <= PROMOTE_CYCLES - 5'd1;
            promote_left_reg <= promote_left_reg - 4'h1;
          end else begin
            seq_state_reg <= SEQ_SCHEDULE;
            seq_count_reg <= SCHEDULE_CYCLES - 5'd1;
          end
        end
        SEQ_SCHEDULE: begin
          if (seq_count_reg != 5'd0) begin
            seq_count_reg <= seq_count_reg - 5'd1;
          end else begin
            seq_state_reg <= SEQ_IDLE;
          end
        end
        default: begin
          seq_state_reg <= SEQ_IDLE;
        end
      endcase
    end
  end

  // elapsed cycles since validation, busy and done outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      window_reg <= REG16_RESET;
      proc_busy  <= 1'b0;
      proc_done  <= 1'b0;
    end else begin
      proc_done <= seq_finish;
      proc_busy <= seq_start || ((seq_state_reg != SEQ_IDLE) && !seq_finish);
      if (seq_start) begin
        window_reg <= 16'h0001;
      end else if (seq_state_reg != SEQ_IDLE && window_reg != 16'hFFFF) begin
        window_reg <= window_reg + 16'h0001;
      end
    end
  end

  // sticky overrun flag; write one clears, a new overrun wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_reg <= 1'b0;
    end else if (seq_finish && (window_reg > budget_cycles)) begin
      overrun_reg <= 1'b1;
    end else if (wr_access && wr_index == IDX_STATUS && pwdata[ST_OVERRUN_BIT]) begin
      overrun_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // checks
  a_counters_mirror: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 error_counters_reg == {$past(receive_error_count), $past(transmit_error_count)})
    else $error("error counters do not mirror the inputs");

  a_diag_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    error_diagnostic_reg[DG_RES_BIT] == 1'b0)
    else $error("reserved diagnostic bit set");

  a_diag_capture: assert property (@(posedge pclk) disable iff (!presetn)
    error_detect |=> error_diagnostic_reg[DG_TXE_BIT-1:0]
                     == {$past(bit_position_reg), $past(field_code_reg)})
    else $error("diagnostic did not capture field and position");

  a_position_load: assert property (@(posedge pclk) disable iff (!presetn)
    field_start ##1 (bit_tick && !field_start)
    |=> bit_position_reg == 6'($past(field_length, 2) - 7'h02))
    else $error("bit position not loaded and decremented");

  a_flag_capture: assert property (@(posedge pclk) disable iff (!presetn)
    error_detect |=> error_diagnostic_reg[DG_MON_BIT:DG_TXE_BIT]
                     == {$past(rx_level_reg), $past(error_crc), $past(error_stuff),
                         $past(transmitting)})
    else $error("diagnostic flags wrong");

  a_stamp_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (time_stamp_enable && buf0_transfer_done) |=> bit_time_stamp_counter_reg == 16'h0000)
    else $error("stamp counter not cleared");

  a_stamp_count: assert property (@(posedge pclk) disable iff (!presetn)
    (bit_tick && !(time_stamp_enable && buf0_transfer_done))
    |=> bit_time_stamp_counter_reg == $past(bit_time_stamp_counter_reg) + 16'h0001)
    else $error("stamp counter did not count");

  a_stamp_handoff: assert property (@(posedge pclk) disable iff (!presetn)
    frame_done |=> stamp_write && stamp_value == $past(bit_time_stamp_counter_reg))
    else $error("stamp not handed to buffer");

  a_rx_gated: assert property (@(posedge pclk) disable iff (!presetn)
    !config_reg[CFG_ENABLE_BIT] |=> rx_bit == RECESSIVE)
    else $error("receive path open while disabled");

  a_tx_polarity: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> transmit_pin == ($past(tx_bit) ^ $past(config_reg[CFG_TXPOL_BIT])))
    else $error("transmit polarity wrong");

  a_copy_length: assert property (@(posedge pclk) disable iff (!presetn)
    seq_start |=> (seq_state_reg == SEQ_COPY) [*8] ##1 (seq_state_reg == SEQ_COPY) [*8]
                  ##1 (seq_state_reg == SEQ_COPY) ##1 (seq_state_reg != SEQ_COPY))
    else $error("copy phase not 17 cycles");

  a_overrun_set: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_finish && window_reg > budget_cycles) |=> overrun_reg)
    else $error("overrun not flagged");
endmodule

// >>> verif/can_transceiver_model.sv
`timescale 1ns/1ps
// ==========================================================================
// transceiver model: wired bus with one foreign node
module can_transceiver_model (
  // node side
  input  wire logic transmit_pin,
  // foreign node pulls the bus dominant
  input  wire logic foreign_dominant,
  // bus level seen by the node
  output logic      receive_pin
);
  // dominant low wins, recessive high when nobody drives
  assign receive_pin = transmit_pin & ~foreign_dominant;
endmodule

// >>> verif/can_error_diag_timestamp_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin err_total++; \
  $display("unexpected %s exp %0h got %0h", nm, e, a); end end
module can_error_diag_timestamp_tb;
  import can_diag_pkg::*;
  // ==========================================================================
  // stimulus and observed signals
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 0, receive_error_count = 0, transmit_error_count = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic receive_pin, transmit_pin, tx_bit = 0, rx_bit, module_enable, foreign = 0;
  logic [12:0] bit_timing_config;
  logic bit_tick = 0, field_start = 0, error_detect = 0, error_stuff = 0, error_crc = 0;
  logic transmitting = 0, buf0_transfer_done = 0, frame_done = 0, stamp_write;
  logic remote_frame_valid = 0, proc_busy, proc_done, last_err;
  field_code_e field_code = FLD_ERROR;
  logic [6:0] field_length = 0;
  logic [3:0] frame_buffer = 0, stamp_buffer, promote_count = 0;
  logic [15:0] stamp_value;
  int err_total = 0, n_checks = 0, cyc = 0, stamp = 0, len, k, cnt, lst[3] = '{0, 1, 14};

  can_error_diag_timestamp u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .receive_pin, .transmit_pin, .tx_bit, .rx_bit,
    .module_enable, .bit_timing_config, .bit_tick, .field_start, .field_code,
    .field_length, .error_detect, .error_stuff, .error_crc, .transmitting,
    .receive_error_count, .transmit_error_count, .buf0_transfer_done, .frame_done,
    .frame_buffer, .stamp_write, .stamp_value, .stamp_buffer, .remote_frame_valid,
    .promote_count, .proc_busy, .proc_done);
  can_transceiver_model u_xcvr (.transmit_pin(transmit_pin), .foreign_dominant(foreign),
    .receive_pin(receive_pin));

  // clock and hang guard
  initial forever #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end

  // ==========================================================================
  // apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata; last_err = pslverr; psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(43));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    foreach (lst[i]) begin
      apb(0, 8'h04 + 8'(4 * i), 0);
      `CHK("reset value", 32'h0, q)
    end
    apb(1, OFS_BIT_TIMING, 32'h0040);
    apb(1, OFS_GLOBAL_CONFIG, 32'h1);
    receive_error_count <= 8'($urandom); transmit_error_count <= 8'($urandom);
    apb(1, OFS_ERROR_COUNTERS, 32'hFFFF);
    apb(0, OFS_ERROR_COUNTERS, 0);
    `CHK("error_counters", {16'h0, receive_error_count, transmit_error_count}, q)
    apb(0, 8'h18, 0);
    `CHK("unmapped", 33'h1_0000_0000, {last_err, q})
    // every field code, random position and flags
    for (int c = 0; c < 16; c++) begin
      len = 2 + $urandom_range(60); k = $urandom_range(len - 1);
      tx_bit <= 1'($urandom); foreign <= 1'($urandom);
      repeat (4) @(posedge pclk);
      field_start <= 1; field_code <= field_code_e'(c); field_length <= 7'(len);
      @(posedge pclk);
      field_start <= 0;
      repeat (k) begin
        bit_tick <= 1;
        stamp++;
        @(posedge pclk);
      end
      bit_tick <= 0; error_detect <= 1; error_stuff <= 1'($urandom);
      error_crc <= 1'($urandom); transmitting <= 1'($urandom);
      @(posedge pclk);
      error_detect <= 0;
      apb(0, OFS_ERROR_DIAG, 0);
      `CHK("error_diagnostic", {17'h0, tx_bit, tx_bit & ~foreign, error_crc, error_stuff, transmitting, 6'(len - 1 - k), 4'(c)}, q)
    end
    apb(0, OFS_STAMP_COUNTER, 0);
    `CHK("stamp counter", 32'(stamp[15:0]), q)
    frame_buffer <= 4'($urandom); frame_done <= 1;
    @(posedge pclk);
    frame_done <= 0;
    @(posedge pclk);
    `CHK("stamp write", {1'b1, stamp[15:0], frame_buffer}, {stamp_write, stamp_value, stamp_buffer})
    // buffer 0 transfer with stamp enable off, then on
    for (int en = 0; en < 2; en++) begin
      apb(1, OFS_GLOBAL_CONFIG, 32'h1 | 32'(en << 1));
      buf0_transfer_done <= 1;
      @(posedge pclk);
      buf0_transfer_done <= 0;
      if (en == 1) stamp = 0;
      apb(0, OFS_STAMP_COUNTER, 0);
      `CHK("stamp after buffer 0", 32'(stamp[15:0]), q)
    end
    // inverted pins, then disabled module
    tx_bit <= 0; foreign <= 0;
    apb(1, OFS_GLOBAL_CONFIG, 32'hD);
    repeat (4) @(posedge pclk);
    `CHK("pins inverted", 2'b10, {transmit_pin, rx_bit})
    apb(0, OFS_PROC_STATUS, 0);
    `CHK("idle before disable", 2'b00, {proc_busy, q[ST_BUSY_BIT]})
    apb(1, OFS_GLOBAL_CONFIG, 32'h0);
    repeat (4) @(posedge pclk);
    `CHK("rx when disabled", {2'b10, 13'h0040}, {rx_bit, module_enable, bit_timing_config})
    apb(0, OFS_BIT_TIMING, 0);
    `CHK("timing kept", 32'h0040, q)
    // remote frame answer at eight-clock bit timing (0x0040)
    foreach (lst[i]) begin
      promote_count <= 4'(lst[i]); remote_frame_valid <= 1;
      @(posedge pclk);
      remote_frame_valid <= 0; cnt = 0;
      do begin
        @(posedge pclk);
        cnt++;
        if (cnt == 1) `CHK("proc busy", 1'b1, proc_busy)
      end while (proc_done !== 1'b1 && cnt < 200);
      `CHK("answer cycles", 20 + 3 * lst[i], cnt)
      apb(0, OFS_PROC_STATUS, 0);
      `CHK("overrun", lst[i] == 14, q[ST_OVERRUN_BIT])
      `CHK("slow clock", 1'b1, q[ST_SLOWCLK_BIT])
      apb(1, OFS_PROC_STATUS, 32'h2);
    end
    // long bit time: 2 * (1 + 16 + 8) clocks, four bits well above 61
    apb(1, OFS_BIT_TIMING, 32'h1FC0);
    apb(0, OFS_PROC_STATUS, 0);
    `CHK("slow clock", 1'b0, q[ST_SLOWCLK_BIT])
    conclude();
  end
endmodule
